/* rtl/slcr_pkg.sv */
// Package of offsets, resets, field positions and carriers for the link config registers
package slcr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] SLCR_ADDR_FRAMES_PER_MF = 12'h202;
    localparam logic [11:0] SLCR_ADDR_SOFT_SYNC     = 12'h203;
    localparam logic [11:0] SLCR_ADDR_LINK_CTRL     = 12'h204;
    localparam logic [11:0] SLCR_ADDR_LINK_TEST     = 12'h205;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SLCR_RST_FRAMES_PER_MF = 8'h1F;
    localparam logic [7:0] SLCR_RST_SOFT_SYNC     = 8'h01;
    localparam logic [7:0] SLCR_RST_LINK_CTRL     = 8'h03;
    localparam logic [7:0] SLCR_RST_LINK_TEST     = 8'h00;
    localparam logic [11:0] SLCR_RST_EFF_K        = 12'h020;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SLCR_SOFT_SYNC_BIT   = 0;
    localparam int SLCR_SCR_BIT         = 0;
    localparam int SLCR_SFMT_BIT        = 1;
    localparam int SLCR_SYNC_SEL_LSB    = 2;
    localparam int SLCR_LANE_MAP_BIT    = 4;
    localparam int SLCR_TEST_SEL_LSB    = 0;
    localparam int SLCR_TEST_SEL_W      = 5;

    // ------------------------------------------------------------
    // Sync source codes and constants
    // ------------------------------------------------------------
    localparam logic [1:0] SLCR_SYNC_SRC_SE_PIN  = 2'h0;
    localparam logic [1:0] SLCR_SYNC_SRC_TS_PIN  = 2'h1;
    localparam logic [1:0] SLCR_SYNC_SRC_NONE    = 2'h2;
    localparam logic [11:0] SLCR_K64_SCALE       = 12'h100;
    localparam logic [7:0]  SLCR_LANES_LOWER     = 8'h0F;
    localparam logic [7:0]  SLCR_LANES_UPPER     = 8'hF0;

    typedef enum logic {
        SLCR_CODING_OFFSET_BIN,
        SLCR_CODING_TWOS_COMP
    } slcr_coding_t;

    // Static settings handed to the link layer
    typedef struct packed {
        logic [11:0]  frames_per_mf;
        slcr_coding_t sample_coding_sel;
        logic         scramble_en;
        logic [4:0]   link_test_sel;
    } slcr_link_cfg_t;

    // Enables and resets for the link layer
    typedef struct packed {
        logic       link_rst;
        logic       mf_counter_rst;
        logic       serdes_pwr_en;
        logic       link_clk_en;
        logic [7:0] lane_pwr_en_a;
        logic [7:0] lane_pwr_en_b;
    } slcr_link_pwr_t;

endpackage : slcr_pkg

/* rtl/slcr_serial_link_config_regs.sv */
// Configuration register bank for the serial output link transmitter
`timescale 1ns/1ps

module slcr_serial_link_config_regs
    import slcr_pkg::*;
(
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    // Register port
    input  wire logic [11:0]              reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_wdata,
    output logic      [7:0]               reg_rdata,
    // Mode and enable from neighbouring registers
    input  wire logic                     link_iface_enable,
    input  wire logic                     mode_is_64b66b,
    input  wire logic [3:0]               mode_e_param,
    input  wire logic [4:0]               mode_f_param,
    // Sync sources
    input  wire logic                     single_ended_sync_pin,
    input  wire logic                     timestamp_pin,
    input  wire logic                     timestamp_receiver_enable,
    // Link layer controls
    output slcr_pkg::slcr_link_cfg_t      link_cfg,
    output slcr_pkg::slcr_link_pwr_t      link_pwr,
    output logic                          link_resync_req
);
    import slcr_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Frames per multiframe as seen by the link layer
    function automatic logic [11:0] slcr_eff_k(input logic        is64,
                                                input logic [7:0]  km1,
                                                input logic [3:0]  e,
                                                input logic [4:0]  f);
        logic [11:0] scaled;
        scaled = SLCR_K64_SCALE * {8'h00, e};
        if (is64 && (f != 5'h00)) begin
            slcr_eff_k = scaled / {7'h00, f};
        end else begin
            slcr_eff_k = {4'h0, km1} + 12'h001;
        end
    endfunction

    function automatic logic slcr_hit(input logic [11:0] a, input logic [11:0] off);
        slcr_hit = (a == off);
    endfunction

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] frames_q;
    logic [7:0] soft_sync_q;
    logic [7:0] ctrl_q;
    logic [7:0] test_q;

    // Full bytes kept so reserved bits read back as written
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frames_q <= SLCR_RST_FRAMES_PER_MF;
        end else if (reg_wr && slcr_hit(reg_addr, SLCR_ADDR_FRAMES_PER_MF)) begin
            frames_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            soft_sync_q <= SLCR_RST_SOFT_SYNC;
        end else if (reg_wr && slcr_hit(reg_addr, SLCR_ADDR_SOFT_SYNC)) begin
            soft_sync_q <= reg_wdata;
        end
    end

    // No write guard on link enable: the software side must stop the link first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= SLCR_RST_LINK_CTRL;
        end else if (reg_wr && slcr_hit(reg_addr, SLCR_ADDR_LINK_CTRL)) begin
            ctrl_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            test_q <= SLCR_RST_LINK_TEST;
        end else if (reg_wr && slcr_hit(reg_addr, SLCR_ADDR_LINK_TEST)) begin
            test_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (slcr_hit(reg_addr, SLCR_ADDR_FRAMES_PER_MF)) begin
            rdata_d = frames_q;
        end else if (slcr_hit(reg_addr, SLCR_ADDR_SOFT_SYNC)) begin
            rdata_d = soft_sync_q;
        end else if (slcr_hit(reg_addr, SLCR_ADDR_LINK_CTRL)) begin
            rdata_d = ctrl_q;
        end else if (slcr_hit(reg_addr, SLCR_ADDR_LINK_TEST)) begin
            rdata_d = test_q;
        end
    end

    // Data held until the next read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic       soft_sync_req_low;
    logic [1:0] sync_src_sel;
    logic       upper_lane_map;
    logic       sample_coding_sel;
    logic       scrambler_on;
    logic [4:0] link_test_sel;

    assign soft_sync_req_low = soft_sync_q[SLCR_SOFT_SYNC_BIT];
    assign sync_src_sel      = ctrl_q[SLCR_SYNC_SEL_LSB +: 2];
    assign upper_lane_map    = ctrl_q[SLCR_LANE_MAP_BIT];
    assign sample_coding_sel = ctrl_q[SLCR_SFMT_BIT];
    assign scrambler_on      = ctrl_q[SLCR_SCR_BIT];
    assign link_test_sel     = test_q[SLCR_TEST_SEL_LSB +: SLCR_TEST_SEL_W];

    // ------------------------------------------------------------
    // Sync request
    // ------------------------------------------------------------
    logic pin_sync_req;
    logic resync_d;

    // Pins are active low; code 3 treated like code 2
    always_comb begin
        case (sync_src_sel)
            SLCR_SYNC_SRC_SE_PIN: pin_sync_req = ~single_ended_sync_pin;
            SLCR_SYNC_SRC_TS_PIN: pin_sync_req = timestamp_receiver_enable & ~timestamp_pin;
            SLCR_SYNC_SRC_NONE:   pin_sync_req = 1'b0;
            default:              pin_sync_req = 1'b0;
        endcase
    end

    // Software request ORed in regardless of source
    assign resync_d = ~soft_sync_req_low | pin_sync_req;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_resync_req <= 1'b0;
        end else begin
            link_resync_req <= resync_d & link_iface_enable;
        end
    end

    // ------------------------------------------------------------
    // Link configuration
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_cfg.frames_per_mf     <= SLCR_RST_EFF_K;
            link_cfg.sample_coding_sel <= SLCR_CODING_TWOS_COMP;
            link_cfg.scramble_en       <= 1'b1;
            link_cfg.link_test_sel     <= 5'h00;
        end else begin
            link_cfg.frames_per_mf     <= slcr_eff_k(mode_is_64b66b, frames_q,
                                                     mode_e_param, mode_f_param);
            link_cfg.sample_coding_sel <= sample_coding_sel ? SLCR_CODING_TWOS_COMP
                                                            : SLCR_CODING_OFFSET_BIN;
            link_cfg.scramble_en       <= mode_is_64b66b | scrambler_on;
            link_cfg.link_test_sel     <= link_test_sel;
        end
    end

    // ------------------------------------------------------------
    // Power, reset and lane enables
    // ------------------------------------------------------------
    // Lane count against mapping is not checked; the mode choice is software's
    logic [7:0] lane_sel;

    assign lane_sel = upper_lane_map ? SLCR_LANES_UPPER : SLCR_LANES_LOWER;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            link_pwr.link_rst       <= 1'b1;
            link_pwr.mf_counter_rst <= 1'b1;
            link_pwr.serdes_pwr_en  <= 1'b0;
            link_pwr.link_clk_en    <= 1'b0;
            link_pwr.lane_pwr_en_a  <= 8'h00;
            link_pwr.lane_pwr_en_b  <= 8'h00;
        end else begin
            link_pwr.link_rst       <= ~link_iface_enable;
            link_pwr.mf_counter_rst <= ~link_iface_enable;
            link_pwr.serdes_pwr_en  <= link_iface_enable;
            link_pwr.link_clk_en    <= link_iface_enable;
            link_pwr.lane_pwr_en_a  <= link_iface_enable ? lane_sel : 8'h00;
            link_pwr.lane_pwr_en_b  <= link_iface_enable ? lane_sel : 8'h00;
        end
    end

endmodule // slcr_serial_link_config_regs

/* bench/slcr_regs_props.sv */
// Checker for the link configuration register bank
`timescale 1ns/1ps

module slcr_regs_props
    import slcr_pkg::*;
(
    input wire logic            sys_clk, rst, reg_wr, reg_rd,
    input wire logic [11:0]     reg_addr,
    input wire logic [7:0]      reg_wdata, reg_rdata,
    input wire logic            link_iface_enable, mode_is_64b66b,
    input wire logic [3:0]      mode_e_param,
    input wire logic [4:0]      mode_f_param,
    input wire logic            single_ended_sync_pin, timestamp_pin, timestamp_receiver_enable,
    input slcr_link_cfg_t       link_cfg,
    input slcr_link_pwr_t       link_pwr,
    input wire logic            link_resync_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----
    // Shadow copies, so outputs tie back to what was written
    // ----
    logic [7:0] km_q, ss_q, ctl_q;
    logic       live_q, pin_req;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            km_q <= SLCR_RST_FRAMES_PER_MF;
            ss_q <= SLCR_RST_SOFT_SYNC;
            ctl_q <= SLCR_RST_LINK_CTRL;
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
            if (reg_wr && reg_addr == SLCR_ADDR_FRAMES_PER_MF) km_q <= reg_wdata;
            if (reg_wr && reg_addr == SLCR_ADDR_SOFT_SYNC) ss_q <= reg_wdata;
            if (reg_wr && reg_addr == SLCR_ADDR_LINK_CTRL) ctl_q <= reg_wdata;
        end
    end
    assign pin_req = (ctl_q[3:2] == 2'h0) ? !single_ended_sync_pin :
                     (ctl_q[3:2] == 2'h1) ? (timestamp_receiver_enable && !timestamp_pin) : 1'b0;

    a_k_reg: assert property (live_q && !$past(mode_is_64b66b) |-> link_cfg.frames_per_mf == {4'h0, $past(km_q)} + 12'h001) else $error("K from register wrong");
    a_k_derived: assert property (live_q && $past(mode_is_64b66b) && $past(mode_f_param) != 5'h00 |-> link_cfg.frames_per_mf == {$past(mode_e_param), 8'h00} / {7'h00, $past(mode_f_param)}) else $error("Derived K wrong");
    a_sync_req: assert property (live_q && $past(link_iface_enable) |-> link_resync_req == $past(!ss_q[0] || pin_req)) else $error("Resync request wrong");
    a_lane_map: assert property (live_q && $past(link_iface_enable) |-> link_pwr.lane_pwr_en_a == ($past(ctl_q[4]) ? SLCR_LANES_UPPER : SLCR_LANES_LOWER) && link_pwr.lane_pwr_en_b == link_pwr.lane_pwr_en_a) else $error("Lane map wrong");
    a_link_off: assert property (live_q && !$past(link_iface_enable) |-> link_pwr.link_rst && link_pwr.mf_counter_rst && !link_pwr.serdes_pwr_en && !link_pwr.link_clk_en && link_pwr.lane_pwr_en_a == 8'h00 && !link_resync_req) else $error("Disabled link not held");
    a_coding_sel: assert property (live_q |-> link_cfg.sample_coding_sel == $past(ctl_q[1])) else $error("Sample coding wrong");
    a_scr_8b: assert property (live_q && !$past(mode_is_64b66b) |-> link_cfg.scramble_en == $past(ctl_q[0])) else $error("Scrambler bit ignored");
    a_scr_64b: assert property (live_q && $past(mode_is_64b66b) |-> link_cfg.scramble_en) else $error("64b66b not scrambled");
    a_read_back: assert property (reg_rd && reg_addr == SLCR_ADDR_LINK_CTRL |=> reg_rdata == $past(ctl_q)) else $error("Control read back wrong");
    a_unmapped_rd: assert property (reg_rd && (reg_addr < 12'h202 || reg_addr > 12'h205) |=> reg_rdata == 8'h00) else $error("Unmapped read not zero");
endmodule // slcr_regs_props

bind slcr_serial_link_config_regs slcr_regs_props u_props (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .link_iface_enable(link_iface_enable), .mode_is_64b66b(mode_is_64b66b), .mode_e_param(mode_e_param),
    .mode_f_param(mode_f_param), .single_ended_sync_pin(single_ended_sync_pin), .timestamp_pin(timestamp_pin),
    .timestamp_receiver_enable(timestamp_receiver_enable), .link_cfg(link_cfg), .link_pwr(link_pwr),
    .link_resync_req(link_resync_req));

/* bench/slcr_sync_rx_model.sv */
// Receiver-side model that raises active-low sync requests on the pins
`timescale 1ns/1ps

module slcr_sync_rx_model (
    input wire logic  sys_clk,
    input wire logic  want_se,
    input wire logic  want_ts,
    output logic      se_n,
    output logic      ts_n
);
    initial se_n = 1'b1;
    initial ts_n = 1'b1;
    // Registered, as a receiver in its own logic would drive them
    always @(posedge sys_clk) se_n <= !want_se;
    always @(posedge sys_clk) ts_n <= !want_ts;
endmodule // slcr_sync_rx_model

/* bench/slcr_serial_link_config_regs_tb.sv */
// Self-checking testbench for the link configuration register bank
`timescale 1ns/1ps

module slcr_serial_link_config_regs_tb;
    import slcr_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, en = 1'b0, m64 = 1'b0;
    logic ts_en = 1'b0, want_se = 1'b0, want_ts = 1'b0, se_n, ts_n, resync;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [3:0] e = 4'h0;
    logic [4:0] f = 5'h00;
    slcr_link_cfg_t cfg;
    slcr_link_pwr_t pwr;
    int failures = 0, checked = 0;
    initial forever #25 sys_clk = !sys_clk;

    slcr_serial_link_config_regs u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_iface_enable(en),
        .mode_is_64b66b(m64), .mode_e_param(e), .mode_f_param(f), .single_ended_sync_pin(se_n),
        .timestamp_pin(ts_n), .timestamp_receiver_enable(ts_en), .link_cfg(cfg), .link_pwr(pwr),
        .link_resync_req(resync));
    slcr_sync_rx_model u_rx (.sys_clk(sys_clk), .want_se(want_se), .want_ts(want_ts), .se_n(se_n), .ts_n(ts_n));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        chk(cfg.frames_per_mf, 16'h0020);
        chk(cfg.sample_coding_sel, 16'h0001);
        rd(SLCR_ADDR_FRAMES_PER_MF, 8'h1F);
        rd(SLCR_ADDR_SOFT_SYNC, 8'h01);
        rd(SLCR_ADDR_LINK_CTRL, 8'h03);
        rd(SLCR_ADDR_LINK_TEST, 8'h00);
        rd(12'h206, 8'h00);
    endtask
    task automatic t_fields;
        wr(SLCR_ADDR_LINK_CTRL, 8'hF3);
        wr(SLCR_ADDR_LINK_TEST, 8'hFF);
        wr(12'h201, 8'h55);
        en <= 1'b1;
        settle();
        rd(SLCR_ADDR_LINK_CTRL, 8'hF3);
        rd(SLCR_ADDR_LINK_TEST, 8'hFF);
        chk(cfg.link_test_sel, 16'h001F);
        chk({pwr.lane_pwr_en_a, pwr.lane_pwr_en_b}, 16'hF0F0);
        en <= 1'b0;
        wr(SLCR_ADDR_LINK_CTRL, 8'h00);
        en <= 1'b1;
        settle();
        chk({pwr.lane_pwr_en_a, pwr.lane_pwr_en_b}, 16'h0F0F);
        chk({cfg.sample_coding_sel, cfg.scramble_en}, 16'h0000);
        m64 <= 1'b1;
        settle();
        chk(cfg.scramble_en, 16'h0001);
    endtask
    task automatic t_k;
        en <= 1'b0;
        m64 <= 1'b0;
        wr(SLCR_ADDR_FRAMES_PER_MF, 8'hFF);
        settle();
        chk(cfg.frames_per_mf, 16'h0100);
        m64 <= 1'b1;
        e <= 4'h3;
        f <= 5'h04;
        settle();
        chk(cfg.frames_per_mf, 16'h00C0);
        f <= 5'h00;
        settle();
        chk(cfg.frames_per_mf, 16'h0100);
        m64 <= 1'b0;
    endtask
    task automatic t_sync;
        ts_en <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            en <= 1'b0;
            wr(SLCR_ADDR_LINK_CTRL, 8'(s << 2));
            en <= 1'b1;
            settle();
            chk(resync, 16'h0000);
            want_se <= 1'b1;
            want_ts <= 1'b1;
            settle();
            chk(resync, {15'h0000, s < 2});
            wr(SLCR_ADDR_SOFT_SYNC, 8'h00);
            settle();
            chk(resync, 16'h0001);
            wr(SLCR_ADDR_SOFT_SYNC, 8'h01);
            settle();
            chk(resync, {15'h0000, s < 2});
            want_se <= 1'b0;
            want_ts <= 1'b0;
        end
        en <= 1'b0;
        wr(SLCR_ADDR_LINK_CTRL, 8'h04);
        en <= 1'b1;
        want_ts <= 1'b1;
        ts_en <= 1'b0;
        settle();
        chk(resync, 16'h0000);
        want_ts <= 1'b1;
        en <= 1'b0;
        settle();
        chk({pwr.link_rst, pwr.mf_counter_rst, pwr.serdes_pwr_en, pwr.link_clk_en, resync}, 16'h0018);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1 t_reset();
        t_fields();
        t_k();
        t_sync();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        complete_run();
    end
endmodule // slcr_serial_link_config_regs_tb
